// ### hdl/error_queue.sv
// error queue: first in, first out store of error codes
// assumes DEPTH is a power of two; push and pop come from the same clock
`timescale 1ns/1ps
`default_nettype none
module error_queue
  import status_pkg::*;
#(
  parameter int DEPTH = ERRQ_DEPTH,
  parameter int W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic push,
  input wire logic [W-1:0] push_code,
  input wire logic pop,
  // state
  output logic [W-1:0] head_code,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] LAST_FREE = (AW+1)'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] rd_r, wr_r, rd_base, wr_base;
  logic [AW:0] cnt_r, cnt_base;
  wire do_pop = pop && !empty && !clear;
  wire room = (cnt_base - (do_pop ? (AW+1)'(1) : '0)) < FULL;
  wire do_push = push && room;
  // last free slot holds the overflow marker
  wire last_slot = (cnt_base - (do_pop ? (AW+1)'(1) : '0)) == LAST_FREE;
  wire [W-1:0] wr_code = last_slot ? W'(ERR_OVERFLOW) : push_code;

  assign rd_base = clear ? '0 : rd_r;
  assign wr_base = clear ? '0 : wr_r;
  assign cnt_base = clear ? '0 : cnt_r;
  assign empty = cnt_r == '0;
  assign head_code = mem_r[rd_r];

  // ======
  // storage and pointers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= '0;
      wr_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      rd_r <= do_pop ? rd_base + AW'(1) : rd_base;
      wr_r <= do_push ? wr_base + AW'(1) : wr_base;
      cnt_r <= cnt_base + (do_push ? (AW+1)'(1) : '0) - (do_pop ? (AW+1)'(1) : '0);
      if (do_push) begin
        mem_r[wr_base] <= wr_code;
      end
    end
  end
endmodule : error_queue
`default_nettype wire

// ### hdl/status_memory.sv
// status reporting, identification, setpoint save/recall and error queue
// assumes an upstream parser delivering decoded commands and the reply
// formatter that turns replies into text
// Function
// - set mask bit passes status bit
// - summary bit6 is OR of enabled bits
// - zero mask never raises service request
// - only mask bits 4 and 5 act
// - mask written and read as integer
// - identity reply: company, model, serial fields
// - save setpoints, protections, period to 0..99
// - recall restores saved set from 0..99
// - recall aborts before changing parameters
// - abort cancels trigger, clears continuous initiation
// - power-up recalls last used location
// - reset: output off, levels 0, prot 110%
// - reset command also aborts
// - errors queued; query returns code plus message
// - error group sets event status bit
// - fixed codes for listed error kinds
// - full queue drops errors, reports overflow
// - status byte follows its summaries; event status latches
// - operation, questionable registers follow present state
// - event enable masks event summary
// - event status read returns then clears
// - event summary is OR of enabled events
// - message available while reply waits
`timescale 1ns/1ps
`default_nettype none
module status_memory
  import status_pkg::*;
#(
  parameter int W = 16,
  parameter int VOLT_MAX = 1000,
  parameter int CURR_MAX = 1000,
  parameter logic [31:0] COMPANY_ID = 32'h0000_0a01, // arbitrary value
  parameter logic [31:0] MODEL_ID = 32'h0000_0b02, // arbitrary value
  parameter logic [31:0] SERIAL_ID = 32'h0000_0c03 // arbitrary value
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // decoded commands
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [4:0] cmd_op,
  input wire logic [2:0] cmd_sel,
  input wire logic [15:0] cmd_arg,
  // parser errors and completion events
  input wire logic perr_valid,
  output logic perr_ready,
  input wire logic [15:0] perr_code,
  input wire logic opc_event,
  // replies
  output logic reply_valid,
  input wire logic reply_ready,
  output logic [31:0] reply_data,
  output logic [2:0] reply_tag,
  output logic [2:0] reply_msg,
  // present conditions, from pins
  input wire logic [15:0] oper_cond,
  input wire logic [15:0] ques_cond,
  input wire logic [6:0] pwr_loc,
  // status
  output logic [7:0] status_byte,
  output logic srq,
  // supply state
  output logic [W-1:0] volt_set,
  output logic [W-1:0] curr_set,
  output logic [W-1:0] volt_trig,
  output logic [W-1:0] curr_trig,
  output logic [W-1:0] volt_prot,
  output logic [W-1:0] curr_prot,
  output logic [W-1:0] period_setting,
  output logic output_on,
  output logic init_cont,
  output logic trig_armed,
  output logic [6:0] cur_loc
);
  localparam logic [W-1:0] VPROT_RST = W'(VOLT_MAX * PROT_PCT / PCT_DIV);
  localparam logic [W-1:0] CPROT_RST = W'(CURR_MAX * PROT_PCT / PCT_DIV);
  localparam int EW = 5 * W;

  // ======
  // registers
  state_t state_r, state_nxt;
  logic [7:0] sre_r, ese_r, esr_r, stb_r;
  logic [15:0] oper_s1_r, oper_r, ques_s1_r, ques_r;
  logic [W-1:0] vset_r, cset_r, vtrig_r, ctrig_r, vprot_r, cprot_r, per_r;
  logic out_r, cont_r, armed_r;
  logic [6:0] loc_r, rcl_loc_r;
  logic [EW-1:0] mem_r [MEM_LOCS];
  logic rv_r;
  logic [31:0] rdata_r;
  logic [2:0] rtag_r, rmsg_r;
  logic [15:0] eq_head;
  logic eq_empty;

  // ======
  // command decode
  wire go = cmd_valid && cmd_ready;
  wire is_op_sre = cmd_op == OP_SET_SRE;
  wire is_op_ese = cmd_op == OP_SET_ESE;
  wire loc_cmd = cmd_op == OP_SAVE || cmd_op == OP_RECALL || cmd_op == OP_SET_MEM;
  wire loc_bad = loc_cmd && cmd_arg > LOC_LAST;
  wire byte_bad = (is_op_sre || is_op_ese) && cmd_arg > BYTE_MAX;
  wire op_known = cmd_op <= OP_QRY_MEM;
  wire int_err = go && (loc_bad || byte_bad || !op_known);
  wire [15:0] int_code = op_known ? ERR_RANGE : ERR_SYNTAX;
  wire do_save = go && cmd_op == OP_SAVE && !loc_bad;
  wire do_recall = go && cmd_op == OP_RECALL && !loc_bad;
  wire do_reset = go && cmd_op == OP_RESET;
  wire do_clear = go && cmd_op == OP_CLEAR;
  wire do_set = go && cmd_op == OP_SET_PARAM;
  wire do_abort = go && (cmd_op == OP_ABORT || cmd_op == OP_RESET) || state_r == ST_RCL_ABORT;
  wire do_trig = go && cmd_op == OP_TRIGGER && armed_r;
  wire rd_esr = go && cmd_op == OP_QRY_ESR;
  wire rd_err = go && cmd_op == OP_QRY_ERR;
  wire rcl_load = state_r == ST_RCL_LOAD;
  wire [EW-1:0] rcl_word = mem_r[rcl_loc_r];

  assign cmd_ready = state_r == ST_IDLE && !rv_r;
  assign perr_ready = !int_err;

  // ==========================================================
  // error queue and event status
  wire push = int_err || perr_valid;
  wire [15:0] push_code = int_err ? int_code : perr_code;
  wire [15:0] err_mag = 16'(-push_code);
  wire [7:0] grp_bits;
  assign grp_bits[ESR_CME_BIT] = push && err_mag >= GRP_100 && err_mag < GRP_200;
  assign grp_bits[ESR_EXE_BIT] = push && err_mag >= GRP_200 && err_mag < GRP_300;
  assign grp_bits[ESR_DDE_BIT] = push && err_mag >= GRP_300 && err_mag < GRP_400;
  assign grp_bits[ESR_QYE_BIT] = push && err_mag >= GRP_400 && err_mag < GRP_500;
  assign grp_bits[ESR_OPC_BIT] = opc_event;
  assign grp_bits[1] = 1'b0;
  assign grp_bits[6] = 1'b0;
  assign grp_bits[ESR_PON_BIT] = 1'b0;
  // a clear never loses an event of the same cycle
  wire [7:0] esr_nxt = ((rd_esr || do_clear) ? 8'h00 : esr_r) | grp_bits;

  error_queue #(.DEPTH(ERRQ_DEPTH), .W(16)) u_errq (
    .clock(clock),
    .rst_n(rst_n),
    .clear(do_clear),
    .push(push),
    .push_code(push_code),
    .pop(rd_err),
    .head_code(eq_head),
    .empty(eq_empty)
  );

  function automatic logic [2:0] msg_of(input logic [15:0] code);
    case (code)
      ERR_NONE: msg_of = MSG_NONE;
      ERR_CMD: msg_of = MSG_CMD;
      ERR_SYNTAX: msg_of = MSG_SYNTAX;
      ERR_PARAM: msg_of = MSG_PARAM;
      ERR_RANGE: msg_of = MSG_RANGE;
      ERR_OVERFLOW: msg_of = MSG_OVERFLOW;
      ERR_QUERY: msg_of = MSG_QUERY;
      default: msg_of = MSG_OTHER;
    endcase
  endfunction : msg_of

  // ======
  // status byte
  wire esb = |(esr_r & ese_r);
  wire [7:0] stb_low = {2'b00, esb, rv_r, 4'h0};
  wire mss = |(stb_low & sre_r & SRE_USED_MASK);
  wire [7:0] stb_nxt = stb_low | (8'(mss) << STB_MSS_BIT);
  assign status_byte = stb_r;
  assign srq = stb_r[STB_MSS_BIT];

  // ======
  // reply selection
  logic [31:0] qval;
  logic [W-1:0] pval;
  always_comb begin
    case (cmd_sel)
      SEL_VOLT: pval = vset_r;
      SEL_CURR: pval = cset_r;
      SEL_VOLT_PROT: pval = vprot_r;
      SEL_CURR_PROT: pval = cprot_r;
      SEL_PERIOD: pval = per_r;
      SEL_VOLT_TRIG: pval = vtrig_r;
      SEL_CURR_TRIG: pval = ctrig_r;
      default: pval = W'(out_r);
    endcase
    case (cmd_op)
      OP_QRY_SRE: qval = {24'h00_0000, sre_r};
      OP_QRY_ESE: qval = {24'h00_0000, ese_r};
      OP_QRY_ESR: qval = {24'h00_0000, esr_r};
      OP_QRY_STB: qval = {24'h00_0000, stb_r};
      OP_QRY_IDN: qval = COMPANY_ID;
      OP_QRY_ERR: qval = eq_empty ? 32'h0000_0000 : {{16{eq_head[15]}}, eq_head};
      OP_QRY_PARAM: qval = 32'(pval);
      OP_QRY_OPER: qval = {16'h0000, oper_r};
      OP_QRY_QUES: qval = {16'h0000, ques_r};
      OP_QRY_MEM: qval = {25'h000_0000, loc_r};
      default: qval = 32'h0000_0000;
    endcase
  end
  wire is_query = cmd_op == OP_QRY_SRE || cmd_op == OP_QRY_ESE || cmd_op == OP_QRY_ESR
    || cmd_op == OP_QRY_STB || cmd_op == OP_QRY_IDN || cmd_op == OP_QRY_ERR
    || cmd_op == OP_QRY_PARAM || cmd_op == OP_QRY_OPER || cmd_op == OP_QRY_QUES
    || cmd_op == OP_QRY_MEM;
  wire [2:0] qtag = cmd_op == OP_QRY_IDN ? TAG_IDN_COMPANY
    : (cmd_op == OP_QRY_ERR ? TAG_ERROR : TAG_NUMBER);
  wire [2:0] qmsg = cmd_op == OP_QRY_ERR ? (eq_empty ? MSG_NONE : msg_of(eq_head)) : MSG_NONE;
  wire rtake = rv_r && reply_ready;
  wire idn_more = rtag_r == TAG_IDN_COMPANY || rtag_r == TAG_IDN_MODEL;

  assign reply_valid = rv_r;
  assign reply_data = rdata_r;
  assign reply_tag = rtag_r;
  assign reply_msg = rmsg_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rv_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rtag_r <= TAG_NUMBER;
      rmsg_r <= MSG_NONE;
    end else if (go && is_query && op_known) begin
      rv_r <= 1'b1;
      rdata_r <= qval;
      rtag_r <= qtag;
      rmsg_r <= qmsg;
    end else if (rtake && idn_more) begin
      rdata_r <= rtag_r == TAG_IDN_COMPANY ? MODEL_ID : SERIAL_ID;
      rtag_r <= rtag_r == TAG_IDN_COMPANY ? TAG_IDN_MODEL : TAG_IDN_SERIAL;
    end else if (rtake || do_clear) begin
      rv_r <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer: power-up recall, recall abort then load
  always_comb begin
    case (state_r)
      ST_PWRUP: state_nxt = 16'(pwr_loc) > LOC_LAST ? ST_IDLE : ST_RCL_ABORT;
      ST_IDLE: state_nxt = do_recall ? ST_RCL_ABORT : ST_IDLE;
      ST_RCL_ABORT: state_nxt = ST_RCL_LOAD;
      ST_RCL_LOAD: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_PWRUP;
      rcl_loc_r <= 7'h00;
      loc_r <= 7'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_PWRUP) begin
        rcl_loc_r <= pwr_loc;
        loc_r <= pwr_loc;
      end else if (do_recall || do_save || (go && cmd_op == OP_SET_MEM && !loc_bad)) begin
        rcl_loc_r <= cmd_arg[6:0];
        loc_r <= cmd_arg[6:0];
      end
    end
  end

  // ==========================================================
  // status registers and condition synchronisers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sre_r <= SRE_RESET;
      ese_r <= ESE_RESET;
      esr_r <= ESR_RESET;
      stb_r <= 8'h00;
      oper_s1_r <= 16'h0000;
      oper_r <= 16'h0000;
      ques_s1_r <= 16'h0000;
      ques_r <= 16'h0000;
    end else begin
      if (go && is_op_sre && !byte_bad) begin
        sre_r <= cmd_arg[7:0];
      end
      if (go && is_op_ese && !byte_bad) begin
        ese_r <= cmd_arg[7:0];
      end
      esr_r <= esr_nxt;
      stb_r <= stb_nxt;
      oper_s1_r <= oper_cond;
      oper_r <= oper_s1_r;
      ques_s1_r <= ques_cond;
      ques_r <= ques_s1_r;
    end
  end

  // ==========================================================
  // setpoints, trigger state and stored locations
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {vset_r, cset_r, vtrig_r, ctrig_r, per_r} <= '0;
      vprot_r <= VPROT_RST;
      cprot_r <= CPROT_RST;
      {out_r, cont_r, armed_r} <= 3'b000;
      for (int i = 0; i < MEM_LOCS; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      if (do_abort) begin
        armed_r <= 1'b0;
        cont_r <= 1'b0;
      end else if (go && cmd_op == OP_INITIATE) begin
        armed_r <= 1'b1;
        cont_r <= cmd_arg[0];
      end else if (do_trig) begin
        armed_r <= cont_r;
      end
      if (do_reset) begin
        {vset_r, cset_r, vtrig_r, ctrig_r} <= '0;
        vprot_r <= VPROT_RST;
        cprot_r <= CPROT_RST;
        out_r <= 1'b0;
      end else if (rcl_load) begin
        {vset_r, cset_r, vprot_r, cprot_r, per_r} <= rcl_word;
      end else if (do_trig) begin
        vset_r <= vtrig_r;
        cset_r <= ctrig_r;
      end else if (do_set) begin
        case (cmd_sel)
          SEL_VOLT: vset_r <= W'(cmd_arg);
          SEL_CURR: cset_r <= W'(cmd_arg);
          SEL_VOLT_PROT: vprot_r <= W'(cmd_arg);
          SEL_CURR_PROT: cprot_r <= W'(cmd_arg);
          SEL_PERIOD: per_r <= W'(cmd_arg);
          SEL_VOLT_TRIG: vtrig_r <= W'(cmd_arg);
          SEL_CURR_TRIG: ctrig_r <= W'(cmd_arg);
          default: out_r <= cmd_arg[0];
        endcase
      end
      if (do_save) begin
        mem_r[cmd_arg[6:0]] <= {vset_r, cset_r, vprot_r, cprot_r, per_r};
      end
    end
  end

  assign volt_set = vset_r;
  assign curr_set = cset_r;
  assign volt_trig = vtrig_r;
  assign curr_trig = ctrig_r;
  assign volt_prot = vprot_r;
  assign curr_prot = cprot_r;
  assign period_setting = per_r;
  assign output_on = out_r;
  assign init_cont = cont_r;
  assign trig_armed = armed_r;
  assign cur_loc = loc_r;
endmodule : status_memory
`default_nettype wire

// ### inc/status_pkg.sv
// constants, encodings and reset values shared by the status and state memory logic
// assumes an upstream text parser that hands over decoded commands and parse errors
package status_pkg;

  // ======
  // status byte and event status layout
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  localparam logic [7:0] SRE_USED_MASK = 8'h30;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam int ESR_OPC_BIT = 0;
  localparam int ESR_QYE_BIT = 2;
  localparam int ESR_DDE_BIT = 3;
  localparam int ESR_EXE_BIT = 4;
  localparam int ESR_CME_BIT = 5;
  localparam int ESR_PON_BIT = 7;
  localparam logic [15:0] BYTE_MAX = 16'h00ff;

  // ======
  // error codes, two's complement
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_CMD = 16'hff9c;
  localparam logic [15:0] ERR_SYNTAX = 16'hff9a;
  localparam logic [15:0] ERR_PARAM = 16'hff94;
  localparam logic [15:0] ERR_RANGE = 16'hff22;
  localparam logic [15:0] ERR_OVERFLOW = 16'hfea2;
  localparam logic [15:0] ERR_QUERY = 16'hfe70;
  // group boundaries on the error magnitude
  localparam logic [15:0] GRP_100 = 16'h0064;
  localparam logic [15:0] GRP_200 = 16'h00c8;
  localparam logic [15:0] GRP_300 = 16'h012c;
  localparam logic [15:0] GRP_400 = 16'h0190;
  localparam logic [15:0] GRP_500 = 16'h01f4;

  // message text index handed to the reply formatter
  typedef enum logic [2:0] {
    MSG_NONE = 3'b000,
    MSG_CMD = 3'b001,
    MSG_SYNTAX = 3'b010,
    MSG_PARAM = 3'b011,
    MSG_RANGE = 3'b100,
    MSG_OVERFLOW = 3'b101,
    MSG_QUERY = 3'b110,
    MSG_OTHER = 3'b111
  } msg_t;

  // ======
  // state memory
  localparam int MEM_LOCS = 100;
  localparam logic [15:0] LOC_LAST = 16'h0063;
  localparam int PROT_PCT = 110;
  localparam int PCT_DIV = 100;
  localparam int ERRQ_DEPTH = 8;

  // ======
  // decoded commands
  typedef enum logic [4:0] {
    OP_NOP = 5'b00000,
    OP_SET_SRE = 5'b00001,
    OP_QRY_SRE = 5'b00010,
    OP_SET_ESE = 5'b00011,
    OP_QRY_ESE = 5'b00100,
    OP_QRY_ESR = 5'b00101,
    OP_QRY_STB = 5'b00110,
    OP_QRY_IDN = 5'b00111,
    OP_SAVE = 5'b01000,
    OP_RECALL = 5'b01001,
    OP_RESET = 5'b01010,
    OP_CLEAR = 5'b01011,
    OP_QRY_ERR = 5'b01100,
    OP_SET_PARAM = 5'b01101,
    OP_QRY_PARAM = 5'b01110,
    OP_INITIATE = 5'b01111,
    OP_TRIGGER = 5'b10000,
    OP_ABORT = 5'b10001,
    OP_QRY_OPER = 5'b10010,
    OP_QRY_QUES = 5'b10011,
    OP_SET_MEM = 5'b10100,
    OP_QRY_MEM = 5'b10101
  } cmd_op_t;

  // parameter selector for OP_SET_PARAM / OP_QRY_PARAM
  typedef enum logic [2:0] {
    SEL_VOLT = 3'b000,
    SEL_CURR = 3'b001,
    SEL_VOLT_PROT = 3'b010,
    SEL_CURR_PROT = 3'b011,
    SEL_PERIOD = 3'b100,
    SEL_VOLT_TRIG = 3'b101,
    SEL_CURR_TRIG = 3'b110,
    SEL_OUTPUT = 3'b111
  } sel_t;

  // reply word kinds
  typedef enum logic [2:0] {
    TAG_NUMBER = 3'b000,
    TAG_IDN_COMPANY = 3'b001,
    TAG_IDN_MODEL = 3'b010,
    TAG_IDN_SERIAL = 3'b011,
    TAG_ERROR = 3'b100
  } tag_t;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'b000,
    ST_IDLE = 3'b001,
    ST_RCL_ABORT = 3'b010,
    ST_RCL_LOAD = 3'b011
  } state_t;

endpackage : status_pkg

// ### verification/host_model.sv
// host model: takes reply words promptly, at random or not at all
// assumes the ready/valid reply port of status_memory
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic clock,
  // pacing: 0 prompt, 1 random, 2 held off
  input wire logic [1:0] pace,
  // reply port
  input wire logic reply_valid,
  output logic reply_ready
);
  initial begin
    reply_ready = 1'b0;
  end
  always @(negedge clock) begin
    reply_ready <= pace == 2'd0 || (pace == 2'd1 && $urandom_range(0, 1) == 1);
  end
endmodule : host_model
`default_nettype wire

// ### verification/status_memory_properties.sv
// checker: port-level properties of status_memory
// assumes it is bound to status_memory and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module status_memory_checker
  import status_pkg::*;
#(
  parameter int W = 16,
  parameter int VOLT_MAX = 1000,
  parameter int CURR_MAX = 1000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // commands and replies
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [4:0] cmd_op,
  input wire logic [15:0] cmd_arg,
  input wire logic reply_valid,
  input wire logic reply_ready,
  // status
  input wire logic [7:0] status_byte,
  input wire logic srq,
  // supply state
  input wire logic [W-1:0] volt_set,
  input wire logic [W-1:0] curr_set,
  input wire logic [W-1:0] volt_trig,
  input wire logic [W-1:0] curr_trig,
  input wire logic [W-1:0] volt_prot,
  input wire logic [W-1:0] curr_prot,
  input wire logic output_on,
  input wire logic init_cont,
  input wire logic trig_armed,
  input wire logic [6:0] cur_loc
);
  localparam logic [W-1:0] VPROT = W'(VOLT_MAX * PROT_PCT / PCT_DIV);
  localparam logic [W-1:0] CPROT = W'(CURR_MAX * PROT_PCT / PCT_DIV);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ======
  // command decodes
  wire logic take = cmd_valid && cmd_ready;
  wire logic rcl_ok = take && cmd_op == OP_RECALL && cmd_arg <= LOC_LAST;
  wire logic rcl_bad = take && cmd_op == OP_RECALL && cmd_arg > LOC_LAST;
  // ======
  // properties
  a_srq_summary: assert property (srq == status_byte[6])
    else $error("srq mismatch");
  a_summary_cause: assert property (status_byte[6] |-> |status_byte[5:4])
    else $error("stray summary");
  a_unused_zero: assert property ((status_byte & 8'h8f) == 8'h00)
    else $error("unused status bit set");
  a_mav_follows: assert property (status_byte[4] == $past(reply_valid))
    else $error("bad message flag");
  a_reply_holds: assert property (reply_valid && !reply_ready |=> reply_valid)
    else $error("reply dropped");
  a_query_answers: assert property (take && cmd_op == OP_QRY_SRE |=> reply_valid)
    else $error("no mask reply");
  a_recall_aborts: assert property (rcl_ok |=> !cmd_ready [*2] ##1 !trig_armed && !init_cont)
    else $error("recall did not abort");
  a_recall_loc: assert property (rcl_ok |=> ##2 cur_loc == 7'($past(cmd_arg, 3)))
    else $error("recall location not taken");
  a_abort_clears: assert property (take && cmd_op == OP_ABORT |=> !trig_armed && !init_cont)
    else $error("abort failed");
  a_reset_defaults: assert property (take && cmd_op == OP_RESET |=>
    !output_on && volt_set == 0 && curr_set == 0 && volt_trig == 0 && curr_trig == 0
    && volt_prot == VPROT && curr_prot == CPROT && !init_cont && !trig_armed)
    else $error("reset defaults wrong");
  a_bad_loc_keeps: assert property (rcl_bad |=> $stable(volt_set) && $stable(cur_loc))
    else $error("bad location acted");
endmodule : status_memory_checker
`default_nettype wire

// ### verification/status_reporting_state_memory_test.sv
// testbench: random and corner scenarios for status_memory
// assumes status_pkg, host_model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module status_reporting_state_memory_test;
  import status_pkg::*;
  localparam logic [31:0] IDS [3] = '{32'h0000_1234, 32'h0000_5678, 32'h0000_9abc}; // arbitrary
  localparam logic [7:0] CORNER [5] = '{8'h00, 8'h20, 8'hdf, 8'h10, 8'hff};
  localparam logic [15:0] ECODE [6] = '{ERR_CMD, ERR_SYNTAX, ERR_PARAM, ERR_RANGE, 16'hfed4,
    ERR_QUERY};
  localparam logic [31:0] PROT = 32'(1000 * PROT_PCT / PCT_DIV);
  logic clock, rst_n, cmd_valid, perr_valid, opc_event;
  logic [4:0] cmd_op;
  logic [2:0] cmd_sel;
  logic [15:0] cmd_arg, perr_code, oper_cond, ques_cond;
  logic [6:0] pwr_loc, cur_loc;
  logic [1:0] pace;
  logic cmd_ready, perr_ready, reply_valid, reply_ready, srq, output_on, init_cont, trig_armed;
  logic [31:0] reply_data;
  logic [2:0] reply_tag, reply_msg;
  logic [7:0] status_byte;
  logic [15:0] volt_set, curr_set, volt_trig, curr_trig, volt_prot, curr_prot, period_setting;
  logic [37:0] words[$];
  logic [15:0] pv [5];
  logic [7:0] m;
  int n_fail = 0;
  int total_checks = 0;
  int i;
  status_memory #(.COMPANY_ID(IDS[0]), .MODEL_ID(IDS[1]), .SERIAL_ID(IDS[2])) status_memory_i (.*);
  host_model host_model_i (.*);
  always @(posedge clock) begin
    if (reply_valid === 1'b1 && reply_ready === 1'b1) words.push_back({reply_msg, reply_tag,
      reply_data});
  end
  // ======
  // expectations
  function automatic int grp(input logic [15:0] c);
    int v;
    v = -int'($signed(c));
    return v < 200 ? 5 : v < 300 ? 4 : v < 400 ? 3 : 2;
  endfunction : grp
  function automatic logic [2:0] msg_of(input logic [15:0] c);
    case (c)
      ERR_CMD: return MSG_CMD;
      ERR_SYNTAX: return MSG_SYNTAX;
      ERR_PARAM: return MSG_PARAM;
      ERR_RANGE: return MSG_RANGE;
      ERR_QUERY: return MSG_QUERY;
      default: return MSG_OTHER;
    endcase
  endfunction : msg_of
  // ======
  // drivers and checks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [4:0] op, input logic [2:0] sel, input logic [15:0] arg);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_sel = sel;
    cmd_arg = arg;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n == 200) n_fail++;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask : send
  task automatic ask(input logic [4:0] op, input int k);
    int n;
    words.delete();
    send(op, 3'd0, 16'h0000);
    n = 0;
    while (words.size() < k && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (words.size() < k) n_fail++;
  endtask : ask
  task automatic q(input logic [4:0] op, input logic [31:0] e);
    ask(op, 1);
    chk(words[0][31:0], e);
  endtask : q
  task automatic perr(input logic [15:0] c);
    @(negedge clock);
    perr_valid = 1'b1;
    perr_code = c;
    while (perr_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    perr_valid = 1'b0;
  endtask : perr
  task automatic settle();
    repeat (3) @(negedge clock);
  endtask : settle
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // ======
  // clock, watchdog, tests
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #(25 * 30000);
    n_fail++;
    complete_run();
  end
  initial begin
    {rst_n, cmd_valid, perr_valid, opc_event, cmd_op, cmd_sel, cmd_arg, perr_code} = '0;
    {oper_cond, ques_cond, pace} = '0;
    pwr_loc = 7'd5;
    void'($urandom(32'h5b76));
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    settle();
    chk(32'(cur_loc), 32'd5);
    q(OP_QRY_ESR, 32'h0000_0080);
    q(OP_QRY_ESR, 32'h0000_0000);
    $display("power-up test done");
    send(OP_SET_ESE, 3'd0, 16'h0001);
    @(negedge clock) opc_event = 1'b1;
    @(negedge clock) opc_event = 1'b0;
    settle();
    chk(32'(status_byte[5]), 32'd1);
    send(OP_SET_ESE, 3'd0, 16'h0000);
    settle();
    chk(32'(status_byte[5]), 32'd0);
    send(OP_SET_ESE, 3'd0, 16'h0001);
    for (i = 0; i < 12; i++) begin
      m = i < 5 ? CORNER[i] : 8'($urandom_range(0, 255));
      send(OP_SET_SRE, 3'd0, {8'h00, m});
      q(OP_QRY_SRE, {24'h0, m});
      settle();
      chk(32'(srq), 32'(m[5]));
    end
    send(OP_SET_SRE, 3'd0, 16'h0010);
    pace = 2'd2;
    send(OP_QRY_ESE, 3'd0, 16'h0000);
    settle();
    chk(32'({srq, status_byte[4]}), 32'd3);
    pace = 2'd0;
    settle();
    q(OP_QRY_ESR, 32'h0000_0001);
    $display("status test done");
    for (i = 0; i < 6; i++) begin
      perr(ECODE[i]);
      q(OP_QRY_ESR, 32'd1 << grp(ECODE[i]));
      ask(OP_QRY_ERR, 1);
      chk(words[0][31:0], {{16{ECODE[i][15]}}, ECODE[i]});
      chk(32'(words[0][37:32]), 32'({msg_of(ECODE[i]), TAG_ERROR}));
    end
    for (i = 0; i < 10; i++) perr(ERR_SYNTAX);
    for (i = 0; i < 9; i++) begin
      q(OP_QRY_ERR, i < 7 ? 32'hffff_ff9a : i == 7 ? 32'hffff_fea2 : 0);
    end
    send(5'h1f, 3'd0, 16'h0000);
    q(OP_QRY_ERR, 32'hffff_ff9a);
    $display("error test done");
    for (i = 0; i < 5; i++) begin
      pv[i] = 16'($urandom_range(0, 999));
      send(OP_SET_PARAM, 3'(i), pv[i]);
    end
    send(OP_SAVE, 3'd0, 16'd99);
    send(OP_SET_PARAM, SEL_VOLT, pv[0] ^ 16'h0001);
    send(OP_SET_PARAM, SEL_PERIOD, pv[4] ^ 16'h0001);
    send(OP_INITIATE, 3'd0, 16'h0001);
    settle();
    chk(32'({init_cont, trig_armed}), 32'd3);
    send(OP_RECALL, 3'd0, 16'd99);
    settle();
    chk({volt_set, curr_set}, {pv[0], pv[1]});
    chk({volt_prot, curr_prot}, {pv[2], pv[3]});
    chk(32'(period_setting), 32'(pv[4]));
    chk(32'({init_cont, trig_armed}), 32'd0);
    send(OP_SAVE, 3'd0, 16'd100);
    send(OP_RECALL, 3'd0, 16'd100);
    settle();
    chk({volt_set, 9'h0, cur_loc}, {pv[0], 16'd99});
    for (i = 0; i < 2; i++) begin
      q(OP_QRY_ERR, 32'hffff_ff22);
    end
    $display("memory test done");
    send(OP_SET_PARAM, SEL_VOLT_TRIG, 16'd5);
    send(OP_SET_PARAM, SEL_OUTPUT, 16'd1);
    send(OP_INITIATE, 3'd0, 16'h0001);
    send(OP_RESET, 3'd0, 16'h0000);
    settle();
    chk({volt_set, curr_set}, 32'd0);
    chk({volt_trig, curr_trig}, 32'd0);
    chk(32'({output_on, init_cont, trig_armed}), 32'd0);
    chk({volt_prot, curr_prot}, {PROT[15:0], PROT[15:0]});
    $display("reset test done");
    pace = 2'd1;
    ask(OP_QRY_IDN, 3);
    pace = 2'd0;
    for (i = 0; i < 3; i++) begin
      chk(words[i][31:0], IDS[i]);
      chk(32'(words[i][34:32]), 32'(i + 1));
    end
    oper_cond = 16'($urandom);
    ques_cond = 16'($urandom);
    settle();
    q(OP_QRY_OPER, {16'h0, oper_cond});
    q(OP_QRY_QUES, {16'h0, ques_cond});
    $display("identity and condition test done");
    complete_run();
  end
endmodule : status_reporting_state_memory_test
bind status_memory status_memory_checker #(.W(W), .VOLT_MAX(VOLT_MAX), .CURR_MAX(CURR_MAX))
  status_memory_checker_i (.*);
`default_nettype wire
